// ==== inc/eep_cfg.svh ====
// shared constants for the serial eeprom read link
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH
`define EEP_AW          15
`define EEP_DW          8
`define EEP_BITS        4'h8
`define EEP_DEV_CODE    4'h6    // arbitrary value, both ends must agree
`define EEP_DIR_RD      1'b1
`define EEP_DIR_WR      1'b0
`define EEP_CLK_MHZ     40
`define EEP_SCL_HALF_NS 5000
`define EEP_SCL_HALF_CYC ((`EEP_SCL_HALF_NS * `EEP_CLK_MHZ) / 1000)
`endif

// ==== inc/eep_pkg.sv ====
// state types for both ends of the serial eeprom link
package eep_pkg;
  typedef enum logic [3:0] {
    SL_IDLE = 4'h0,
    SL_CTRL = 4'h1,
    SL_AHI  = 4'h2,
    SL_ALO  = 4'h3,
    SL_WRX  = 4'h4,
    SL_ACK  = 4'h5,
    SL_TXL  = 4'h6,
    SL_TX   = 4'h7,
    SL_TXA  = 4'h8,
    SL_TXW  = 4'h9
  } eep_sl_state_e;
  typedef enum logic [3:0] {
    MS_IDLE = 4'h0,
    MS_STA1 = 4'h1,
    MS_STA2 = 4'h2,
    MS_STA3 = 4'h3,
    MS_LO   = 4'h4,
    MS_HI   = 4'h5,
    MS_STO1 = 4'h6,
    MS_STO2 = 4'h7,
    MS_STO3 = 4'h8
  } eep_ms_state_e;
  typedef enum logic [2:0] {
    STEP_CW  = 3'h0,
    STEP_AHI = 3'h1,
    STEP_ALO = 3'h2,
    STEP_CR  = 3'h3,
    STEP_RD  = 3'h4
  } eep_step_e;
endpackage

// ==== inc/eep_link_if.sv ====
// two-wire link between the eeprom end and the bus master end
`timescale 1ns/10ps
interface eep_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // open-drain wire with pull-up: low whenever an enabled driver drives low
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport slave  (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface

// ==== rtl/eep_slave.sv ====
// eeprom end: control byte match, word address load, random and sequential read
//
// Operation
// RULE_01 - master loads address via write transfer
// RULE_02 - repeated start aborts write, keeps pointer
// RULE_03 - ack read control byte, shift data out
// RULE_04 - master nacks and stops; release data
// RULE_05 - pointer points past last read byte
// RULE_06 - master ack fetches next sequential byte
// RULE_07 - master nacks last byte, then stops
// RULE_08 - pointer increments after each byte
// RULE_09 - pointer wraps from top to zero
// RULE_10 - ack only matching code and select bits
// RULE_11 - two address bytes, high first, msb ignored
// RULE_12 - no ack while programming busy
// RULE_13 - release data line on master nack
// RULE_14 - stop or mismatch returns to idle
`timescale 1ns/10ps
`include "eep_cfg.svh"
module eep_slave #(
  parameter int         AW       = `EEP_AW,
  parameter logic [3:0] DEV_CODE = `EEP_DEV_CODE  // arbitrary value
) (
  // system
  input  wire logic          core_clk,
  input  wire logic          srst,
  // link
  eep_link_if.slave          link,
  // straps and programming status
  input  wire logic [2:0]    chip_select_pins,
  input  wire logic          prog_busy,
  // array load port
  input  wire logic          mem_wr_en,
  input  wire logic [AW-1:0] mem_wr_addr,
  input  wire logic [7:0]    mem_wr_data,
  // status
  output logic      [AW-1:0] addr_ptr,
  output logic               reading
);

  // ****************************************
  // parameter check
  // ****************************************
  if (AW < 9 || AW > 16) begin : g_bad_aw
    $error("eep_slave: AW must lie in 9..16");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic       scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic       sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic [2:0] cs_s1_ff, cs_s2_ff;
  logic       busy_s1_ff, busy_s2_ff;

  // pins from outside; third stage feeds edge detection only from the second
  always_ff @(posedge core_clk) begin
    scl_s1_ff  <= link.scl;
    scl_s2_ff  <= scl_s1_ff;
    scl_s3_ff  <= scl_s2_ff;
    sda_s1_ff  <= link.sda;
    sda_s2_ff  <= sda_s1_ff;
    sda_s3_ff  <= sda_s2_ff;
    cs_s1_ff   <= chip_select_pins;
    cs_s2_ff   <= cs_s1_ff;
    busy_s1_ff <= prog_busy;
    busy_s2_ff <= busy_s1_ff;
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall  = ~scl_s2_ff & scl_s3_ff;
  // data edges while the clock stays high mark start and stop
  assign bus_start = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
  assign bus_stop  = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;

  // ****************************************
  // storage array
  // ****************************************
  logic [7:0] mem [0:(1<<AW)-1];

  // load port only; programming from the link is outside this block
  always_ff @(posedge core_clk) begin
    if (mem_wr_en) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end

  // ****************************************
  // protocol engine
  // ****************************************
  eep_pkg::eep_sl_state_e st_ff, nxt_st, ret_ff, nxt_ret;
  logic [3:0]    cnt_ff, nxt_cnt;
  logic [7:0]    sh_ff, nxt_sh;
  logic [7:0]    hi_ff, nxt_hi;
  logic [AW-1:0] ptr_ff, nxt_ptr;
  logic          oe_ff, nxt_oe;
  logic          rd_ff, nxt_rd;
  logic          o_ff;
  logic [7:0]    rd_byte;

  assign rd_byte = mem[ptr_ff];

  // control byte match, single use but kept apart for readability
  function automatic logic ctrl_match(input logic [7:0] b, input logic [2:0] cs,
                                      input logic busy);
    ctrl_match = (b[7:4] == DEV_CODE) && (b[3:1] == cs) && !busy;
  endfunction

  // next-state logic; start and stop take priority over any bit activity
  always_comb begin
    nxt_st  = st_ff;
    nxt_ret = ret_ff;
    nxt_cnt = cnt_ff;
    nxt_sh  = sh_ff;
    nxt_hi  = hi_ff;
    nxt_ptr = ptr_ff;
    nxt_oe  = oe_ff;
    nxt_rd  = rd_ff;
    if (bus_start) begin
      nxt_st  = eep_pkg::SL_CTRL;             // see RULE_02
      nxt_cnt = 4'h0;
      nxt_oe  = 1'b0;
      nxt_rd  = 1'b0;
    end else if (bus_stop) begin
      nxt_st = eep_pkg::SL_IDLE;              // see RULE_04, see RULE_14
      nxt_oe = 1'b0;
      nxt_rd = 1'b0;
    end else begin
      case (st_ff)
        eep_pkg::SL_IDLE: begin
          nxt_oe = 1'b0;
        end
        eep_pkg::SL_CTRL, eep_pkg::SL_AHI, eep_pkg::SL_ALO, eep_pkg::SL_WRX: begin
          if (scl_rise) begin
            nxt_sh  = {sh_ff[6:0], sda_s2_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `EEP_BITS) begin
            nxt_cnt = 4'h0;
            nxt_st  = eep_pkg::SL_ACK;
            nxt_oe  = 1'b1;                   // pull low for acknowledge
            case (st_ff)
              eep_pkg::SL_CTRL: begin
                if (ctrl_match(sh_ff, cs_s2_ff, busy_s2_ff)) begin // see RULE_10, see RULE_12
                  nxt_ret = (sh_ff[0] == `EEP_DIR_RD) ? eep_pkg::SL_TXL : // see RULE_03
                                                        eep_pkg::SL_AHI;  // see RULE_01
                end else begin
                  nxt_st = eep_pkg::SL_IDLE;  // see RULE_14
                  nxt_oe = 1'b0;
                end
              end
              eep_pkg::SL_AHI: begin
                nxt_hi  = sh_ff;
                nxt_ret = eep_pkg::SL_ALO;
              end
              eep_pkg::SL_ALO: begin
                // top bit of the high byte is a don't-care
                nxt_ptr = {hi_ff[AW-9:0], sh_ff}; // see RULE_11, see RULE_02
                nxt_ret = eep_pkg::SL_WRX;
              end
              default: begin
                nxt_ret = eep_pkg::SL_WRX;    // write data is acked, never programmed
              end
            endcase
          end
        end
        eep_pkg::SL_ACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b0;
            nxt_st = ret_ff;
          end
        end
        eep_pkg::SL_TXL: begin
          // fetch at pointer, step past it; AW-bit add wraps top to zero
          nxt_sh  = rd_byte;                  // see RULE_03, see RULE_06
          nxt_ptr = ptr_ff + 1'b1;            // see RULE_05, see RULE_08, see RULE_09
          nxt_oe  = ~rd_byte[7];
          nxt_cnt = 4'h1;
          nxt_rd  = 1'b1;
          nxt_st  = eep_pkg::SL_TX;
        end
        eep_pkg::SL_TX: begin
          if (scl_fall) begin
            if (cnt_ff == `EEP_BITS) begin
              nxt_oe = 1'b0;                  // free the line for the master's answer
              nxt_st = eep_pkg::SL_TXA;
            end else begin
              nxt_oe  = ~sh_ff[6];
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        eep_pkg::SL_TXA: begin
          if (scl_rise) begin
            if (sda_s2_ff) begin
              nxt_st = eep_pkg::SL_IDLE;      // see RULE_13, see RULE_07
              nxt_rd = 1'b0;
            end else begin
              nxt_st = eep_pkg::SL_TXW;       // see RULE_06
            end
          end
        end
        eep_pkg::SL_TXW: begin
          if (scl_fall) begin
            nxt_st = eep_pkg::SL_TXL;
          end
        end
        default: begin
          nxt_st = eep_pkg::SL_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // state registers; pointer has no reset value of meaning, cleared for determinism
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff  <= eep_pkg::SL_IDLE;
      ret_ff <= eep_pkg::SL_IDLE;
      cnt_ff <= 4'h0;
      sh_ff  <= 8'h00;
      hi_ff  <= 8'h00;
      ptr_ff <= '0;
      oe_ff  <= 1'b0;
      rd_ff  <= 1'b0;
      o_ff   <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      ret_ff <= nxt_ret;
      cnt_ff <= nxt_cnt;
      sh_ff  <= nxt_sh;
      hi_ff  <= nxt_hi;
      ptr_ff <= nxt_ptr;
      oe_ff  <= nxt_oe;
      rd_ff  <= nxt_rd;
      o_ff   <= 1'b0;                         // open drain: only ever drives low
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.sda_s_o  = o_ff;
  assign link.sda_s_oe = oe_ff;
  assign addr_ptr      = ptr_ff;
  assign reading       = rd_ff;

endmodule

// ==== rtl/eep_master.sv ====
// bus master end: random read followed by optional sequential bytes
`timescale 1ns/10ps
`include "eep_cfg.svh"
module eep_master #(
  parameter int         AW       = `EEP_AW,
  parameter int         SCL_HALF = `EEP_SCL_HALF_CYC,
  parameter logic [3:0] DEV_CODE = `EEP_DEV_CODE  // arbitrary value
) (
  // system
  input  wire logic          core_clk,
  input  wire logic          srst,
  // link
  eep_link_if.master         link,
  // read request
  input  wire logic          cmd_valid,
  input  wire logic [2:0]    cmd_sel,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [7:0]    cmd_len,
  output logic               cmd_ready,
  // read answer
  output logic [7:0]         rd_data,
  output logic               rd_valid,
  output logic               done,
  output logic               nack_err
);

  // ****************************************
  // parameter check
  // ****************************************
  if (AW < 9 || AW > 16 || SCL_HALF < 8 || SCL_HALF > 65535) begin : g_bad_par
    $error("eep_master: AW or SCL_HALF out of range");
  end

  // ****************************************
  // data line synchroniser
  // ****************************************
  logic sda_s1_ff, sda_s2_ff;
  always_ff @(posedge core_clk) begin
    sda_s1_ff <= link.sda;
    sda_s2_ff <= sda_s1_ff;
  end

  // ****************************************
  // sequencer
  // ****************************************
  eep_pkg::eep_ms_state_e st_ff, nxt_st;
  eep_pkg::eep_step_e     step_ff, nxt_step;
  logic [15:0]   div_ff, nxt_div;
  logic [3:0]    cnt_ff, nxt_cnt;
  logic [7:0]    tx_ff, nxt_tx, sh_ff, nxt_sh, len_ff, nxt_len;
  logic [2:0]    sel_ff, nxt_sel;
  logic [AW-1:0] adr_ff, nxt_adr;
  logic          scl_ff, nxt_scl, oe_ff, nxt_oe, rdy_ff, nxt_rdy;
  logic [7:0]    dat_ff, nxt_dat;
  logic          rdv_ff, nxt_rdv, done_ff, nxt_done, err_ff, nxt_err;
  logic          tick;

  assign tick = (div_ff == 16'(SCL_HALF - 1));

  // pull-low enable for a bit slot: data bits, then ack slot of the byte
  function automatic logic bit_drive(input logic [3:0] c, input logic rx,
                                     input logic last, input logic [7:0] b);
    if (c < `EEP_BITS) begin
      bit_drive = rx ? 1'b0 : ~b[3'(4'h7 - c)];
    end else begin
      bit_drive = rx ? ~last : 1'b0;          // ack all but the last byte
    end
  endfunction

  // next-state logic; one half clock period per step
  always_comb begin
    nxt_st   = st_ff;
    nxt_step = step_ff;
    nxt_div  = (st_ff == eep_pkg::MS_IDLE || tick) ? 16'h0000 : div_ff + 16'h0001;
    nxt_cnt  = cnt_ff;
    nxt_tx   = tx_ff;
    nxt_sh   = sh_ff;
    nxt_len  = len_ff;
    nxt_sel  = sel_ff;
    nxt_adr  = adr_ff;
    nxt_scl  = scl_ff;
    nxt_oe   = oe_ff;
    nxt_rdy  = rdy_ff;
    nxt_dat  = dat_ff;
    nxt_rdv  = 1'b0;
    nxt_done = 1'b0;
    nxt_err  = 1'b0;
    case (st_ff)
      eep_pkg::MS_IDLE: begin
        if (cmd_valid) begin
          nxt_sel  = cmd_sel;
          nxt_adr  = cmd_addr;
          nxt_len  = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
          nxt_step = eep_pkg::STEP_CW;
          nxt_tx   = {DEV_CODE, cmd_sel, `EEP_DIR_WR}; // see RULE_01
          nxt_rdy  = 1'b0;
          nxt_scl  = 1'b1;                    // clock already high: no stray pulse before start
          nxt_oe   = 1'b0;
          nxt_st   = eep_pkg::MS_STA1;
        end
      end
      eep_pkg::MS_STA1: if (tick) begin
        nxt_scl = 1'b1;
        nxt_st  = eep_pkg::MS_STA2;
      end
      eep_pkg::MS_STA2: if (tick) begin
        nxt_oe = 1'b1;                        // data falls with clock high
        nxt_st = eep_pkg::MS_STA3;
      end
      eep_pkg::MS_STA3: if (tick) begin
        nxt_scl = 1'b0;
        nxt_cnt = 4'h0;
        nxt_st  = eep_pkg::MS_LO;
      end
      eep_pkg::MS_LO: if (tick) begin
        nxt_scl = 1'b1;
        nxt_st  = eep_pkg::MS_HI;
      end
      eep_pkg::MS_HI: if (tick) begin
        nxt_scl = 1'b0;
        nxt_st  = eep_pkg::MS_LO;
        if (cnt_ff < `EEP_BITS) begin
          nxt_sh  = {sh_ff[6:0], sda_s2_ff};
          nxt_cnt = cnt_ff + 4'h1;
        end else begin
          nxt_cnt = 4'h0;
          if (step_ff != eep_pkg::STEP_RD && sda_s2_ff) begin
            nxt_err = 1'b1;                   // no device answered
            nxt_oe  = 1'b1;
            nxt_st  = eep_pkg::MS_STO1;
          end else begin
            case (step_ff)
              eep_pkg::STEP_CW: begin
                nxt_step = eep_pkg::STEP_AHI;
                nxt_tx   = 8'(adr_ff >> 8);   // see RULE_11
              end
              eep_pkg::STEP_AHI: begin
                nxt_step = eep_pkg::STEP_ALO;
                nxt_tx   = adr_ff[7:0];
              end
              eep_pkg::STEP_ALO: begin
                // repeated start instead of data cuts the write short
                nxt_step = eep_pkg::STEP_CR;  // see RULE_02
                nxt_tx   = {DEV_CODE, sel_ff, `EEP_DIR_RD}; // see RULE_03
                nxt_st   = eep_pkg::MS_STA1;
              end
              eep_pkg::STEP_CR: begin
                nxt_step = eep_pkg::STEP_RD;
              end
              default: begin
                nxt_dat = sh_ff;
                nxt_rdv = 1'b1;
                if (len_ff == 8'h01) begin
                  nxt_oe = 1'b1;              // see RULE_04, see RULE_07
                  nxt_st = eep_pkg::MS_STO1;
                end else begin
                  nxt_len = len_ff - 8'h01;   // see RULE_06
                end
              end
            endcase
          end
        end
      end
      eep_pkg::MS_STO1: if (tick) begin
        nxt_scl = 1'b1;
        nxt_st  = eep_pkg::MS_STO2;
      end
      eep_pkg::MS_STO2: if (tick) begin
        nxt_oe = 1'b0;                        // data rises with clock high
        nxt_st = eep_pkg::MS_STO3;
      end
      eep_pkg::MS_STO3: if (tick) begin
        nxt_rdy  = 1'b1;
        nxt_done = 1'b1;
        nxt_st   = eep_pkg::MS_IDLE;
      end
      default: begin
        nxt_st = eep_pkg::MS_IDLE;
      end
    endcase
    // drive for the coming bit slot follows the updated byte context
    if (nxt_st == eep_pkg::MS_LO) begin
      nxt_oe = bit_drive(nxt_cnt, nxt_step == eep_pkg::STEP_RD, nxt_len == 8'h01, nxt_tx);
    end
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff   <= eep_pkg::MS_IDLE;
      step_ff <= eep_pkg::STEP_CW;
      div_ff  <= 16'h0000;
      cnt_ff  <= 4'h0;
      tx_ff   <= 8'h00;
      sh_ff   <= 8'h00;
      len_ff  <= 8'h00;
      sel_ff  <= 3'h0;
      adr_ff  <= '0;
      scl_ff  <= 1'b1;
      oe_ff   <= 1'b0;
      rdy_ff  <= 1'b1;
      dat_ff  <= 8'h00;
      rdv_ff  <= 1'b0;
      done_ff <= 1'b0;
      err_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      step_ff <= nxt_step;
      div_ff  <= nxt_div;
      cnt_ff  <= nxt_cnt;
      tx_ff   <= nxt_tx;
      sh_ff   <= nxt_sh;
      len_ff  <= nxt_len;
      sel_ff  <= nxt_sel;
      adr_ff  <= nxt_adr;
      scl_ff  <= nxt_scl;
      oe_ff   <= nxt_oe;
      rdy_ff  <= nxt_rdy;
      dat_ff  <= nxt_dat;
      rdv_ff  <= nxt_rdv;
      done_ff <= nxt_done;
      err_ff  <= nxt_err;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.scl      = scl_ff;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = oe_ff;
  assign cmd_ready     = rdy_ff;
  assign rd_data       = dat_ff;
  assign rd_valid      = rdv_ff;
  assign done          = done_ff;
  assign nack_err      = err_ff;

endmodule

// ==== verification/eep_link_properties.sv ====
// concurrent checks on the two-wire link between the eeprom end and the master end
`timescale 1ns/10ps
module eep_link_properties #(
  parameter int SCL_HALF = 8
) (
  // system
  input wire logic core_clk,
  input wire logic srst,
  // link
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic sda
);
  logic       scl_q_ff, sda_q_ff, first_ff, nxt_first;
  logic [3:0] bit_ff, nxt_bit;
  logic [9:0] run_ff, nxt_run;

  // bit position since start; run length of the current scl level
  always_comb begin
    nxt_first = first_ff;
    nxt_bit   = bit_ff;
    nxt_run   = (scl != scl_q_ff) ? 10'h0 : ((run_ff == 10'h3ff) ? run_ff : run_ff + 10'h1);
    if (scl && scl_q_ff && sda_q_ff && !sda) begin
      nxt_bit   = 4'h0;
      nxt_first = 1'b1;
    end else if (scl && !scl_q_ff) begin
      nxt_bit   = (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
      nxt_first = (bit_ff == 4'h8) ? 1'b0 : first_ff;
    end
  end

  // idle counts as a long level so the first fall after reset is legal
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      first_ff <= 1'b0;
      bit_ff   <= 4'h0;
      run_ff   <= 10'h3ff;
    end else begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
      first_ff <= nxt_first;
      bit_ff   <= nxt_bit;
      run_ff   <= nxt_run;
    end
  end

  // ************************************************
  // link properties
  // ************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_RESET_IDLE: assert property ($fell(srst) |-> scl && !sda_m_oe && !sda_s_oe)
    else $error("link not idle after reset");
  AST_SCL_HALF: assert property ($changed(scl) |-> run_ff >= SCL_HALF - 1)
    else $error("scl level shorter than half period");
  AST_START_HOLD: assert property (scl && $fell(sda) |-> scl [*4])
    else $error("scl fell too soon after start");
  AST_STOP_FREE: assert property (scl && $rose(sda) |-> (scl && sda && !sda_s_oe) [*8])
    else $error("bus not free after stop");
  AST_SLAVE_EDGE: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl, 2))
    else $error("eeprom end changed data outside scl low");
  AST_SLAVE_HOLD: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8])
    else $error("eeprom end drive too short");
  AST_CTRL_LISTEN: assert property (first_ff && bit_ff < 4'h8 |-> !sda_s_oe)
    else $error("eeprom end drove during control byte");
  AST_NACK_RELEASE: assert property (
    $rose(scl) && bit_ff == 4'h8 && sda && !sda_s_oe |-> !sda_s_oe [*8])
    else $error("eeprom end drove after nack");
endmodule

// ==== verification/eeprom_random_seq_read_test.sv ====
// self-checking bench: master end reads the eeprom end across the link
`timescale 1ns/10ps
module eeprom_random_seq_read_test;
  // ************************************************
  // signals and model
  // ************************************************
  localparam int HALF = 8;  // short scl half period keeps the run brief
  logic        core_clk;
  logic        srst = 1'b1, cmd_valid = 1'b0, prog_busy = 1'b0, mem_wr_en = 1'b0;
  logic [2:0]  cmd_sel = 3'h0, chip_select_pins = 3'h5;
  logic [14:0] cmd_addr = 15'h0, mem_wr_addr = 15'h0;
  logic [7:0]  cmd_len = 8'h0, mem_wr_data = 8'h0;
  logic        cmd_ready, rd_valid, done, nack_err, reading;
  logic [7:0]  rd_data;
  logic [14:0] addr_ptr;
  logic [7:0]  model_mem [int];
  int          err_count = 0, checked = 0, ptr_model = 0, rbase;

  // ************************************************
  // clock and instances
  // ************************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  eep_link_if link_if ();
  eep_slave eep_slave_inst (
    .core_clk(core_clk), .srst(srst), .link(link_if), .chip_select_pins(chip_select_pins),
    .prog_busy(prog_busy), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .addr_ptr(addr_ptr), .reading(reading));
  eep_master #(.SCL_HALF(HALF)) eep_master_inst (
    .core_clk(core_clk), .srst(srst), .link(link_if), .cmd_valid(cmd_valid),
    .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_err(nack_err));
  eep_link_properties #(.SCL_HALF(HALF)) eep_link_properties_inst (
    .core_clk(core_clk), .srst(srst), .scl(link_if.scl), .sda_m_o(link_if.sda_m_o),
    .sda_m_oe(link_if.sda_m_oe), .sda_s_o(link_if.sda_s_o), .sda_s_oe(link_if.sda_s_oe),
    .sda(link_if.sda));

  // ************************************************
  // tasks
  // ************************************************
  task automatic check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // array preload; every task is entered just after a rising edge
  task automatic load_block(input int base, input int n);
    int a;
    for (int i = 0; i < n; i++) begin
      a = (base + i) % 32768;
      model_mem[a] = 8'($urandom);
      mem_wr_en   <= 1'b1;
      mem_wr_addr <= 15'(a);
      mem_wr_data <= model_mem[a];
      @(posedge core_clk);
    end
    mem_wr_en <= 1'b0;
    @(posedge core_clk);                // next preload may raise the enable again
  endtask

  // one command; the model predicts bytes, count, refusal and pointer
  task automatic do_read(input logic [2:0] sel, input int addr, input int len, input bit refuse);
    int exp_a, got, k, n;
    bit nk, sr;
    exp_a = addr;
    got   = 0;
    k     = 0;
    nk    = 1'b0;
    sr    = 1'b0;
    n     = refuse ? 0 : ((len == 0) ? 1 : len);
    while (cmd_ready !== 1'b1) begin
      @(posedge core_clk);
      k++;
      if (k > 2000) begin
        check(1'b0, "ready timeout");
        end_of_test();
      end
    end
    cmd_valid <= 1'b1;
    cmd_sel   <= sel;
    cmd_addr  <= 15'(addr);
    cmd_len   <= 8'(len);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      k++;
      if (rd_valid === 1'b1) begin
        check(rd_data === model_mem[exp_a], "read data");
        exp_a = (exp_a + 1) % 32768;
        got++;
      end
      if (nack_err === 1'b1) begin
        nk = 1'b1;
      end
      if (reading === 1'b1) begin
        sr = 1'b1;
      end
      if (k > 20000) begin
        check(1'b0, "read timeout");
        end_of_test();
      end
    end while (done !== 1'b1);
    if (!refuse) begin
      ptr_model = (addr + n) % 32768;
    end
    check(got == n, "byte count");
    check(nk == refuse, "control byte answer");
    check(addr_ptr === 15'(ptr_model), "address pointer");
    check(reading === 1'b0 && link_if.sda_s_oe === 1'b0, "still sending after stop");
    check(sr == !refuse, "send flag");
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    void'($urandom(90));
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check(cmd_ready === 1'b1 && addr_ptr === 15'h0 && reading === 1'b0, "reset");
    check(link_if.scl === 1'b1 && link_if.sda === 1'b1, "link idle");
    $display("test reset done");
    rbase = 32'h100 + int'($urandom % 32'h7000);
    load_block(32'h7ffc, 8);
    load_block(rbase, 64);
    do_read(3'h5, rbase + 5, 1, 1'b0);
    $display("test random read done");
    do_read(3'h5, rbase + 10, 16, 1'b0);
    $display("test sequential read done");
    do_read(3'h5, 32'h7ffe, 5, 1'b0);
    $display("test wrap done");
    do_read(3'h5, rbase, 0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      do_read(3'h5, rbase + int'($urandom % 40), 1 + int'($urandom % 8), 1'b0);
    end
    $display("test back to back done");
    // every select code answered, a mismatching one refused
    for (int s = 0; s < 8; s++) begin
      chip_select_pins <= 3'(s);
      repeat (4) @(posedge core_clk);
      do_read(3'(s), rbase + s, 2, 1'b0);
      do_read(3'(s ^ (1 << (s % 3))), rbase, 1, 1'b1);
    end
    $display("test select codes done");
    prog_busy <= 1'b1;
    repeat (4) @(posedge core_clk);
    do_read(3'h7, rbase, 1, 1'b1);
    prog_busy <= 1'b0;
    repeat (4) @(posedge core_clk);
    do_read(3'h7, rbase + 1, 3, 1'b0);
    $display("test busy done");
    end_of_test();
  end
endmodule
